// file: bench/adc_power_fail_compare_ctrl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_power_fail_compare_ctrl_test;
  import apfc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  apfc_bus_t   bus = '0;
  logic [15:0] rd_data;
  logic [9:0]  sar_code;
  logic [9:0]  ain = '0;
  logic        standby = 1'b0;
  logic        irq, sh, pwr;
  logic [2:0]  chan;
  logic        rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          irq_n = 0;
  int          irq_cyc = 0;
  int          prev_cyc = 0;
  int          n0, w0;
  int          sh_run = 0;
  int          sh_len = 0;
  logic [7:0]  thr;
  logic [9:0]  v;
  logic        pol, hit;

  always #20 clk = ~clk;

  // analog input model: comparator against the trial tap
  apfc_ctrl u_apfc_ctrl (
    .CLK          (clk),
    .RST          (rst),
    .BUS          (bus),
    .RD_DATA      (rd_data),
    .COMP_IN      (ain >= sar_code),
    .SAR_CODE     (sar_code),
    .SAMPLE_HOLD  (sh),
    .CHANNEL      (chan),
    .POWER_ON     (pwr),
    .STANDBY      (standby),
    .CONV_END_IRQ (irq)
  );

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus <= '0;
  endtask : rd

  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irq_n < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (irq_n < n) begin
      fail_count++;
      $display("BAD irq_wait expected %0d seen %0d", n, irq_n);
    end
  endtask : wait_irq

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_seen <= bus.rd;
  end

  // read data stands in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      check("rd_data", rd_data, exp_q.pop_front());
    end
    if (sh === 1'b1) begin
      sh_run++;
    end else if (sh_run != 0) begin
      sh_len = sh_run;
      sh_run = 0;
    end
    if (irq === 1'b1) begin
      prev_cyc = irq_cyc;
      irq_cyc = cyc;
      irq_n++;
    end
  end

  initial begin
    repeat (8000) @(posedge clk);
    fail_count++;
    $display("BAD watchdog expected done seen timeout");
    print_verdict();
  end

  initial begin
    void'($urandom(32'h06cc));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) rd(3'(a), 16'h0000);
    $display("test reset_values done");
    @(posedge clk) ain <= 10'($urandom);
    wr(A_CHAN, 8'h03);
    wr(A_MODE, 8'h31);
    repeat (int'(SETTLE_CYC) + 2) @(posedge clk);
    wr(A_MODE, 8'hB1);
    wait_irq(irq_n + 2);
    check("conv_spacing", 16'(irq_cyc - prev_cyc), 16'h0060);
    check("sample_len", 16'(sh_len), 16'h000C);
    rd(A_RES, {ain, 6'h00});
    rd(A_STAT, 16'h0007);
    check("channel", 16'(chan), 16'h0003);
    $display("test plain_conversion done");
    w0 = cyc;
    wr(A_CHAN, 8'h05);
    rd(A_STAT, 16'h0007);
    n0 = irq_n;
    wait_irq(n0 + 1);
    check("restart_len", 16'(irq_cyc - w0 >= 108), 16'h0001);
    check("channel", 16'(chan), 16'h0005);
    rd(A_CHAN, 16'h0005);
    $display("test channel_change done");
    for (int i = 0; i < 8; i++) begin
      pol = i[0];
      thr = 8'($urandom);
      v = (i < 2) ? {thr, 2'($urandom)} : 10'($urandom);
      hit = pol ? (v[9:2] < thr) : (v[9:2] >= thr);
      @(posedge clk) ain <= v;
      wr(A_PFM, {1'b1, pol, 6'h00});
      wr(A_THR, thr);
      wr(A_STAT, 8'h01);
      n0 = irq_n;
      repeat (250) @(posedge clk);
      check("irq_count", 16'(irq_n - n0), hit ? 16'h0002 : 16'h0000);
      rd(A_STAT, {15'h0003, hit});
      rd(A_THR, {8'h00, thr});
      rd(A_PFM, {8'h00, 1'b1, pol, 6'h00});
    end
    $display("test power_fail_compare done");
    wr(A_PFM, 8'h00);
    wr(A_MODE, 8'h01);
    wr(A_STAT, 8'h01);
    wr(A_MODE, 8'h81);
    rd(A_MODE, 16'h0081);
    wait_irq(irq_n + 1);
    wait_irq(irq_n + 1);
    check("conv_spacing", 16'(irq_cyc - prev_cyc), 16'h0120);
    check("sample_len", 16'(sh_len), 16'h0028);
    // new input before the first step, read lands on the end cycle
    @(posedge clk) ain <= ~v;
    repeat (284) @(posedge clk);
    rd(A_RES, {v, 6'h00});
    rd(A_RES, {~v, 6'h00});
    // channel write lands on the next end cycle
    @(posedge clk) ain <= v;
    n0 = irq_n;
    repeat (283) @(posedge clk);
    wr(A_CHAN, 8'h05);
    repeat (2) @(posedge clk);
    check("irq_count", 16'(irq_n - n0), 16'h0000);
    rd(A_RES, {~v, 6'h00});
    $display("test collisions done");
    @(posedge clk) standby <= 1'b1;
    wr(A_STAT, 8'h01);
    n0 = irq_n;
    repeat (250) @(posedge clk);
    check("irq_count", 16'(irq_n - n0), 16'h0000);
    rd(A_STAT, 16'h0004);
    @(posedge clk) standby <= 1'b0;
    wr(A_MODE, 8'h31);
    wr(A_MODE, 8'h00);
    @(negedge clk);
    check("power_on", 16'(pwr), 16'h0000);
    $display("test standby_stop done");
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule : adc_power_fail_compare_ctrl_test
`default_nettype wire

// file: common/apfc_pkg.sv
// constants, types and timing table for the converter control block
// Operation
// - pf mode bit 7 enables threshold comparison instead of unconditional interrupt
// - pf mode bit 6 picks which compare outcome raises the interrupt
// - polarity 0: irq if result[9:2] >= threshold; 1: irq if below
// - at end of conversion store result, then compare and interrupt
// - channel in channel bits 2..0, time in mode bits 5..3, any order
// - channel rewrite while running converts the new channel and compares
// - first conversion after start or change is longer; later ones exact
// - conversion repeats back to back while run bit 7 stays set
// - config register write aborts conversion; restarts if run still set
// - result read colliding with update returns old value, then updates
// - mode or channel write at end of conversion wins; no update, no irq
// - channel rewrite never clears the conversion end flag
// - converter halts in standby; clear run and power-on beforehand
// - result is 10 bits, one lsb being 1/1024 of full scale
// - conversion time counts from sampling start to result
// - sample switch closed for between a seventh and an eighth of each conversion
package apfc_pkg;
  localparam int         CLK_MHZ    = 25;
  localparam int         SETTLE_US  = 14;
  localparam logic [8:0] SETTLE_CYC = 9'(SETTLE_US * CLK_MHZ);

  localparam logic [2:0] A_MODE = 3'h0;
  localparam logic [2:0] A_CHAN = 3'h1;
  localparam logic [2:0] A_PFM  = 3'h2;
  localparam logic [2:0] A_THR  = 3'h3;
  localparam logic [2:0] A_RES  = 3'h4;
  localparam logic [2:0] A_STAT = 3'h5;

  localparam int B_RUN     = 7;
  localparam int B_TS_HI   = 5;
  localparam int B_TS_LO   = 3;
  localparam int B_PWR     = 0;
  localparam int B_PF_EN   = 7;
  localparam int B_PF_POL  = 6;
  localparam int B_CH_HI   = 2;
  localparam int B_FLAG    = 0;

  localparam logic [9:0] SAR_MSB = 10'h200;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} apfc_phase_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } apfc_bus_t;

  typedef struct packed {
    logic       run;
    logic [2:0] ts;
    logic       pwr;
  } apfc_mode_t;

  typedef struct packed {
    logic en;
    logic pol;
  } apfc_pf_t;

  // conversion, sampling, first-start delay, bit step (all in clocks)
  typedef struct packed {
    logic [8:0] conv;
    logic [5:0] samp;
    logic [5:0] dly;
    logic [4:0] stride;
  } apfc_tim_t;

  // prohibited selections fall back to the slowest setting
  localparam apfc_tim_t TIM_TAB [8] = '{
    '{9'h120, 6'h28, 6'h20, 5'h18},
    '{9'h0F0, 6'h20, 6'h1C, 5'h14},
    '{9'h0C0, 6'h18, 6'h18, 5'h10},
    '{9'h120, 6'h28, 6'h20, 5'h18},
    '{9'h090, 6'h14, 6'h10, 5'h0C},
    '{9'h078, 6'h10, 6'h0E, 5'h0A},
    '{9'h060, 6'h0C, 6'h0C, 5'h08},
    '{9'h120, 6'h28, 6'h20, 5'h18}
  };

  typedef struct packed {
    apfc_mode_t  mode;
    logic [2:0]  chan;
    apfc_pf_t    pf;
    logic [7:0]  thr;
    logic [9:0]  result;
    logic        flag;
    logic        irq;
    logic [15:0] rd;
    apfc_phase_t ph;
    logic [8:0]  e;
    logic [4:0]  sc;
    logic [9:0]  sar;
    logic [9:0]  mask;
    logic        sh;
    logic [8:0]  settle;
  } apfc_state_t;
endpackage : apfc_pkg

// file: design/apfc_ctrl.sv
// converter sequencer, register file and power-fail compare
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module apfc_ctrl (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               RST,
  // register port
  input  wire apfc_pkg::apfc_bus_t BUS,
  output logic [15:0]             RD_DATA,
  // analog front end
  input  wire logic               COMP_IN,
  output logic [9:0]              SAR_CODE,
  output logic                    SAMPLE_HOLD,
  output logic [2:0]              CHANNEL,
  output logic                    POWER_ON,
  // system
  input  wire logic               STANDBY,
  output logic                    CONV_END_IRQ
);
  import apfc_pkg::*;

  apfc_state_t q;
  apfc_state_t n;
  apfc_tim_t   tim;
  logic        cfg_wr;
  logic        eoc;
  logic        hit;
  logic        settled;

  assign tim     = TIM_TAB[q.mode.ts];
  assign settled = (q.settle == SETTLE_CYC);
  assign cfg_wr  = BUS.wr && (BUS.addr == A_MODE || BUS.addr == A_CHAN ||
                              BUS.addr == A_PFM  || BUS.addr == A_THR);
  assign eoc     = (q.ph == ST_CONV) && (q.e == (tim.conv - 9'h001));
  // compare the upper eight result bits against the threshold
  assign hit     = !q.pf.en ||
                   (q.pf.pol ? (q.sar[9:2] <  q.thr)
                             : (q.sar[9:2] >= q.thr));

  always_comb begin
    n     = q;
    n.irq = 1'b0;
    n.rd  = 16'h0000;
    // register writes
    if (BUS.wr) begin
      if (BUS.addr == A_MODE) begin
        n.mode.run = BUS.wdata[B_RUN];
        n.mode.ts  = BUS.wdata[B_TS_HI:B_TS_LO];
        n.mode.pwr = BUS.wdata[B_PWR];
      end else if (BUS.addr == A_CHAN) begin
        n.chan = BUS.wdata[B_CH_HI:0];
      end else if (BUS.addr == A_PFM) begin
        n.pf.en  = BUS.wdata[B_PF_EN];
        n.pf.pol = BUS.wdata[B_PF_POL];
      end else if (BUS.addr == A_THR) begin
        n.thr = BUS.wdata;
      end else if (BUS.addr == A_STAT && BUS.wdata[B_FLAG]) begin
        n.flag = 1'b0;
      end
    end
    // register reads, served from the old state
    if (BUS.rd) begin
      if (BUS.addr == A_MODE) begin
        n.rd = {8'h00, q.mode.run, 1'b0, q.mode.ts, 2'b00, q.mode.pwr};
      end else if (BUS.addr == A_CHAN) begin
        n.rd = {13'h0000, q.chan};
      end else if (BUS.addr == A_PFM) begin
        n.rd = {8'h00, q.pf.en, q.pf.pol, 6'h00};
      end else if (BUS.addr == A_THR) begin
        n.rd = {8'h00, q.thr};
      end else if (BUS.addr == A_RES) begin
        n.rd = {q.result, 6'h00};
      end else if (BUS.addr == A_STAT) begin
        n.rd = {13'h0000, settled, (q.ph != ST_IDLE), q.flag};
      end else begin
        n.rd = 16'h0000;
      end
    end
    // power-on settling indication
    if (!n.mode.pwr) begin
      n.settle = 9'h000;
    end else if (!settled) begin
      n.settle = q.settle + 9'h001;
    end
    // sequencer
    if (STANDBY || !n.mode.run) begin
      n.ph = ST_IDLE;
      n.e  = 9'h000;
    end else if (cfg_wr || q.ph == ST_IDLE) begin
      n.ph = ST_DELAY;
      n.e  = 9'h000;
    end else begin
      case (q.ph)
        ST_DELAY: begin
          if (q.e == {3'h0, tim.dly} - 9'h001) begin
            n.ph   = ST_CONV;
            n.e    = 9'h000;
            n.sc   = 5'h00;
            n.sar  = SAR_MSB;
            n.mask = SAR_MSB;
          end else begin
            n.e = q.e + 9'h001;
          end
        end
        ST_CONV: begin
          n.e = q.e + 9'h001;
          // one approximation step per stride after sampling
          if (q.e >= {3'h0, tim.samp} && q.mask != 10'h000) begin
            if (q.sc == tim.stride - 5'h01) begin
              n.sar  = (COMP_IN ? q.sar : (q.sar & ~q.mask)) |
                       (q.mask >> 1);
              n.mask = q.mask >> 1;
              n.sc   = 5'h00;
            end else begin
              n.sc = q.sc + 5'h01;
            end
          end
          if (eoc) begin
            n.result = q.sar;
            n.e      = 9'h000;
            n.sc     = 5'h00;
            n.sar    = SAR_MSB;
            n.mask   = SAR_MSB;
            if (hit) begin
              n.flag = 1'b1;
              n.irq  = 1'b1;
            end
          end
        end
        default: begin
          n.ph = ST_IDLE;
        end
      endcase
    end
    n.sh = (n.ph == ST_CONV) && (n.e < {3'h0, tim.samp});
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign RD_DATA      = q.rd;
  assign SAR_CODE     = q.sar;
  assign SAMPLE_HOLD  = q.sh;
  assign CHANNEL      = q.chan;
  assign POWER_ON     = q.mode.pwr;
  assign CONV_END_IRQ = q.irq;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  logic mode_chan_wr;
  assign mode_chan_wr = BUS.wr && (BUS.addr == A_MODE || BUS.addr == A_CHAN);

  sequence s_eoc_clean;
    eoc && !cfg_wr && !STANDBY;
  endsequence

  sequence s_next_start;
    (q.ph == ST_CONV) && (q.e == 9'h000);
  endsequence

  sequence s_delay_end;
    (q.ph == ST_DELAY) && (q.e == ({3'h0, tim.dly} - 9'h001));
  endsequence

  property p_normal_irq;
    s_eoc_clean and (!q.pf.en) |=> CONV_END_IRQ && q.flag;
  endproperty
  a_normal_irq: assert property (p_normal_irq)
    else $error("normal mode end of conversion gave no interrupt");

  property p_irq_ge;
    s_eoc_clean and (q.pf.en && !q.pf.pol && (q.sar[9:2] >= q.thr))
      |=> CONV_END_IRQ;
  endproperty
  a_irq_ge: assert property (p_irq_ge)
    else $error("result at or above threshold gave no interrupt");

  property p_irq_pol;
    s_eoc_clean and (q.pf.en && (q.pf.pol == (q.sar[9:2] >= q.thr)))
      |=> !CONV_END_IRQ;
  endproperty
  a_irq_pol: assert property (p_irq_pol)
    else $error("interrupt raised although compare condition failed");

  property p_result_store;
    s_eoc_clean |=> q.result == $past(q.sar);
  endproperty
  a_result_store: assert property (p_result_store)
    else $error("result register not loaded at end of conversion");

  property p_write_wins;
    eoc && mode_chan_wr |=> !CONV_END_IRQ && $stable(q.result);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("result updated despite colliding mode or channel write");

  property p_read_old;
    BUS.rd && BUS.addr == A_RES && eoc
      |=> (RD_DATA[15:6] == $past(q.result)) and
          (BUS.rd && BUS.addr == A_RES |=> RD_DATA[15:6] == $past(q.result));
  endproperty
  a_read_old: assert property (p_read_old)
    else $error("colliding result read did not return the old value");

  property p_flag_keep;
    q.flag && BUS.wr && BUS.addr == A_CHAN |=> q.flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("channel rewrite cleared the conversion end flag");

  property p_restart;
    (q.ph == ST_CONV) && cfg_wr && BUS.addr != A_MODE && !STANDBY
      |=> q.ph == ST_DELAY && q.e == 9'h000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("config write did not restart the conversion");

  property p_back_to_back;
    s_eoc_clean and (q.mode.run && !BUS.wr) |=> s_next_start;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("next conversion did not start at once");

  property p_chan_follow;
    BUS.wr && BUS.addr == A_CHAN |=> CHANNEL == $past(BUS.wdata[2:0]);
  endproperty
  a_chan_follow: assert property (p_chan_follow)
    else $error("channel output did not follow the written field");

  property p_stop;
    STANDBY |=> q.ph == ST_IDLE && !SAMPLE_HOLD;
  endproperty
  a_stop: assert property (p_stop)
    else $error("converter kept running in standby");

  property p_irq_lt;
    s_eoc_clean and (q.pf.en && q.pf.pol && (q.sar[9:2] < q.thr))
      |=> CONV_END_IRQ;
  endproperty
  a_irq_lt: assert property (p_irq_lt)
    else $error("result below threshold gave no interrupt");

  property p_irq_pulse;
    CONV_END_IRQ |=> !CONV_END_IRQ;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("conversion end interrupt longer than one cycle");

  property p_set_wins;
    s_eoc_clean and (hit && BUS.wr && BUS.addr == A_STAT &&
                     BUS.wdata[B_FLAG]) |=> q.flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag clear beat a coinciding end of conversion");

  property p_first_conv;
    s_delay_end and (!BUS.wr && !STANDBY) |=> s_next_start;
  endproperty
  a_first_conv: assert property (p_first_conv)
    else $error("conversion did not follow the start delay");

  property p_sample_start;
    s_next_start |-> SAMPLE_HOLD;
  endproperty
  a_sample_start: assert property (p_sample_start)
    else $error("sample switch open at conversion start");

  property p_sample_end;
    (q.ph == ST_CONV) && (q.e == {3'h0, tim.samp}) |-> !SAMPLE_HOLD;
  endproperty
  a_sample_end: assert property (p_sample_end)
    else $error("sample switch still closed after sampling time");

  property p_sar_first;
    s_next_start |-> SAR_CODE == SAR_MSB;
  endproperty
  a_sar_first: assert property (p_sar_first)
    else $error("first trial code is not the top bit");

  property p_idle_quiet;
    q.ph == ST_IDLE |=> !CONV_END_IRQ && !SAMPLE_HOLD;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle converter sampled or interrupted");

  property p_power_follow;
    BUS.wr && BUS.addr == A_MODE |=> POWER_ON == $past(BUS.wdata[B_PWR]);
  endproperty
  a_power_follow: assert property (p_power_follow)
    else $error("power output did not follow the mode write");

  property p_rd_quiet;
    !BUS.rd |=> RD_DATA == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data present without a read strobe");
endmodule : apfc_ctrl
`default_nettype wire
